// ### verilog/fsps_sequencer.sv
// Flash self-program sequencer: APB registers, trigger and region guard.
// Assumes CPU accesses arrive over APB and exec_from_boot is synchronous.
`timescale 1ns/1ps
module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter int AW = APB_AW
)
(
  input wire logic clk, // System clock, 250 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, 1 write
  input wire logic [AW-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic exec_from_boot, // CPU runs in boot region
  input wire logic [3:0] boot_size_opt, // Boot size in 512-byte steps
  input wire logic [7:0] low_bound_opt, // Option value of low bound
  output logic cpu_stall, // CPU halted by operation
  output logic soft_reset_user // Soft reset pulse to user start
);
  fsps_flash_if fl ();

  fsps_flash_array #(
    .AW(FLASH_AW),
    .PW(PAGE_BITS)
  ) u_array (
    .clk(clk),
    .rst_n(rst_n),
    .fl(fl)
  );

  fsps_state_t state_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic enable_reg;
  logic [2:0] mode_reg;
  logic [7:0] low_bound_reg;
  logic lb_loaded_reg;
  logic [7:0] addr_hi_reg;
  logic [7:0] addr_lo_reg;
  logic [7:0] data_reg;
  logic armed_reg;
  logic ignored_reg;
  logic soft_reset_reg;
  logic req_reg;
  fsps_op_t op_reg;
  logic [FLASH_AW-1:0] tgt_reg;
  logic busy;
  logic access;
  logic wr_fire;
  logic trigger;
  logic launch;
  logic [15:0] target;
  logic [15:0] boot_start;
  logic [15:0] low_bound;
  logic mode_ok;
  logic region_ok;

  function automatic logic is_mapped(input logic [AW-1:0] a);
    case (a)
      OFS_CTRL, OFS_MODE, OFS_LOWB, OFS_ADRH,
      OFS_ADRL, OFS_DATA, OFS_CMD, OFS_STAT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  function automatic logic wr_to(input logic fire, input logic [AW-1:0] a,
                                 input logic [AW-1:0] ofs);
    wr_to = fire && (a == ofs);
  endfunction : wr_to

  assign busy = (state_reg == SQ_RUN);
  // Access stalls while the flash works
  assign access = psel && penable && !pready_reg && !busy;
  assign wr_fire = psel && penable && pwrite && pready_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= access;
      pslverr_reg <= access && !is_mapped(paddr);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata_reg <= '0;
    else if (access && !pwrite)
    begin
      case (paddr)
        OFS_CTRL: prdata_reg <= 32'({enable_reg, 7'h00});
        OFS_MODE: prdata_reg <= 32'(mode_reg);
        OFS_LOWB: prdata_reg <= 32'(low_bound_reg);
        OFS_ADRH: prdata_reg <= 32'(addr_hi_reg);
        OFS_ADRL: prdata_reg <= 32'(addr_lo_reg);
        OFS_DATA: prdata_reg <= 32'(data_reg);
        OFS_STAT: prdata_reg <= 32'({boot_size_opt, 1'b0, exec_from_boot,
                                     ignored_reg, busy});
        default: prdata_reg <= '0;
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // Access enable bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      enable_reg <= 1'b0;
    else if (wr_to(wr_fire, paddr, OFS_CTRL))
      enable_reg <= pwdata[EN_BIT];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      soft_reset_reg <= 1'b0;
    else
      soft_reset_reg <= wr_to(wr_fire, paddr, OFS_CTRL)
                        && (pwdata[SWRST_HI:SWRST_LO] == SWRST_USER);
  end

  assign soft_reset_user = soft_reset_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_reg <= MODE_RST;
    else if (wr_to(wr_fire, paddr, OFS_MODE))
      mode_reg <= pwdata[2:0];
  end

  // Option value taken once after release, software may rewrite later
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_bound_reg <= BYTE_RST;
      lb_loaded_reg <= 1'b0;
    end
    else if (wr_to(wr_fire, paddr, OFS_LOWB))
    begin
      low_bound_reg <= pwdata[7:0];
      lb_loaded_reg <= 1'b1;
    end
    else if (!lb_loaded_reg)
    begin
      low_bound_reg <= low_bound_opt;
      lb_loaded_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_hi_reg <= BYTE_RST;
      addr_lo_reg <= BYTE_RST;
    end
    else
    begin
      if (wr_to(wr_fire, paddr, OFS_ADRH))
        addr_hi_reg <= pwdata[7:0];
      if (wr_to(wr_fire, paddr, OFS_ADRL))
        addr_lo_reg <= pwdata[7:0];
    end
  end

  // Read result overrides the register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      data_reg <= BYTE_RST;
    else if (busy && fl.done && op_reg == OP_READ)
      data_reg <= fl.rdata;
    else if (wr_to(wr_fire, paddr, OFS_DATA))
      data_reg <= pwdata[7:0];
  end

  // Any register write between the two keys breaks the sequence
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed_reg <= 1'b0;
    else if (wr_fire)
      armed_reg <= wr_to(wr_fire, paddr, OFS_CMD)
                   && (pwdata[7:0] == CMD_KEY1);
  end

  assign trigger = wr_to(wr_fire, paddr, OFS_CMD) && armed_reg
                   && (pwdata[7:0] == CMD_KEY2);

  assign target = {addr_hi_reg, addr_lo_reg};
  assign boot_start = FLASH_SIZE - 16'({boot_size_opt, {PAGE_BITS{1'b0}}});
  assign low_bound = 16'({low_bound_reg, {LB_SHIFT{1'b0}}});
  assign mode_ok = (mode_reg[2] == 1'b0) && (mode_reg[1:0] != OP_STANDBY);

  // Boot region is never a target, user region below the low bound only from boot code except for reads
  always_comb
  begin
    region_ok = 1'b0;
    if (target < boot_start)
    begin
      if (mode_reg[1:0] == OP_READ)
        region_ok = 1'b1;
      else if (exec_from_boot)
        region_ok = 1'b1;
      else
        region_ok = (target >= low_bound);
    end
  end

  assign launch = trigger && enable_reg && mode_ok && region_ok;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ignored_reg <= 1'b0;
    else if (trigger && !launch)
      ignored_reg <= 1'b1;
    else if (wr_to(wr_fire, paddr, OFS_STAT) && pwdata[ST_IGN_BIT])
      ignored_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= SQ_IDLE;
    else
    begin
      case (state_reg)
        SQ_IDLE:
        begin
          if (launch)
            state_reg <= SQ_RUN;
        end
        SQ_RUN:
        begin
          if (fl.done)
            state_reg <= SQ_IDLE;
        end
        default: state_reg <= SQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_reg <= 1'b0;
      op_reg <= OP_STANDBY;
      tgt_reg <= '0;
    end
    else
    begin
      req_reg <= launch;
      if (launch)
      begin
        op_reg <= fsps_op_t'(mode_reg[1:0]);
        tgt_reg <= target[FLASH_AW-1:0];
      end
    end
  end

  assign fl.req = req_reg;
  assign fl.op = op_reg;
  assign fl.addr = tgt_reg;
  assign fl.wdata = data_reg;
  assign cpu_stall = busy;
endmodule : fsps_sequencer

// ### verilog/fsps_pkg.sv
// Constants, register map and types of the flash self-program sequencer.
// Assumes a 250 MHz clk and an APB master with 32-bit data.
package fsps_pkg;
  localparam int APB_AW = 8;
  localparam int FLASH_AW = 15;
  localparam int PAGE_BITS = 9;
  localparam int LB_SHIFT = 8;
  localparam logic [15:0] FLASH_SIZE = 16'h8000;
  localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFS_MODE = 8'h04;
  localparam logic [APB_AW-1:0] OFS_LOWB = 8'h08;
  localparam logic [APB_AW-1:0] OFS_ADRH = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_ADRL = 8'h10;
  localparam logic [APB_AW-1:0] OFS_DATA = 8'h14;
  localparam logic [APB_AW-1:0] OFS_CMD = 8'h18;
  localparam logic [APB_AW-1:0] OFS_STAT = 8'h1C;
  localparam int EN_BIT = 7;
  localparam int SWRST_HI = 7;
  localparam int SWRST_LO = 5;
  localparam logic [2:0] SWRST_USER = 3'h1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_IGN_BIT = 1;
  localparam int ST_BOOT_BIT = 2;
  localparam int ST_SIZE_LO = 4;
  localparam logic [7:0] CMD_KEY1 = 8'h46;
  localparam logic [7:0] CMD_KEY2 = 8'hB9;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  typedef enum logic [1:0]
  {
    OP_STANDBY = 2'b00,
    OP_READ = 2'b01,
    OP_PROG = 2'b10,
    OP_ERASE = 2'b11
  } fsps_op_t;
  typedef enum logic [0:0]
  {
    SQ_IDLE = 1'b0,
    SQ_RUN = 1'b1
  } fsps_state_t;
endpackage : fsps_pkg

// ### verilog/fsps_flash_if.sv
// Request and answer signals between sequencer and flash array.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface fsps_flash_if;
  import fsps_pkg::*;
  logic req;
  fsps_op_t op;
  logic [FLASH_AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic done;
  modport ctl (output req, op, addr, wdata, input rdata, done);
  modport mem (input req, op, addr, wdata, output rdata, done);
endinterface : fsps_flash_if

// ### verilog/fsps_flash_array.sv
// Embedded 32K-byte flash array with program, page erase and read.
// Assumes one-cycle req pulses, never sent while an operation runs.
`timescale 1ns/1ps
module fsps_flash_array
  import fsps_pkg::*;
#(
  parameter int AW = FLASH_AW,
  parameter int PW = PAGE_BITS
)
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  fsps_flash_if.mem fl // Request port
);
  logic [7:0] mem_reg [0:(1<<AW)-1];
  logic erasing_reg;
  logic [PW-1:0] cnt_reg;
  logic [AW-1:PW] page_reg;
  logic done_reg;
  logic [7:0] rdata_reg;

  // Erase walks the page one byte per cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      erasing_reg <= 1'b0;
      cnt_reg <= '0;
      page_reg <= '0;
    end
    else if (fl.req && fl.op == OP_ERASE)
    begin
      erasing_reg <= 1'b1;
      cnt_reg <= '0;
      page_reg <= fl.addr[AW-1:PW];
    end
    else if (erasing_reg)
    begin
      cnt_reg <= cnt_reg + 1'b1;
      if (&cnt_reg)
        erasing_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (fl.req && fl.op == OP_PROG)
      mem_reg[fl.addr] <= mem_reg[fl.addr] & fl.wdata;
    else if (erasing_reg)
      mem_reg[{page_reg, cnt_reg}] <= ERASED_BYTE;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= BYTE_RST;
      done_reg <= 1'b0;
    end
    else
    begin
      if (fl.req && fl.op == OP_READ)
        rdata_reg <= mem_reg[fl.addr];
      done_reg <= (fl.req && fl.op != OP_ERASE) || (erasing_reg && (&cnt_reg));
    end
  end

  assign fl.rdata = rdata_reg;
  assign fl.done = done_reg;
endmodule : fsps_flash_array

// ### dv/fsps_flash_ref.sv
// Reference image of the flash array, kept by the bench.
// Assumes the bench calls it only for operations that must run.
`timescale 1ns/1ps
module fsps_flash_ref;
  logic [7:0] mem [0:32767];
  task automatic erase(input logic [15:0] a);
    for (int i = 0; i < 512; i++)
      mem[{a[14:9], i[8:0]}] = 8'hFF;
  endtask : erase
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    mem[a[14:0]] = mem[a[14:0]] & d;
  endtask : prog
endmodule : fsps_flash_ref

// ### dv/fsps_chk.sv
// Checker for the sequencer top ports.
// Assumes one clock domain and APB access from one master.
`timescale 1ns/1ps
module fsps_chk
  import fsps_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic exec_from_boot, // Boot execution
  input wire logic [3:0] boot_size_opt, // Boot size
  input wire logic [7:0] low_bound_opt, // Low bound option
  input wire logic cpu_stall, // Stall
  input wire logic soft_reset_user // Soft reset
);
  logic wr_done;
  logic trig_ok;
  logic en_reg;
  logic key_reg;
  logic [2:0] mode_reg;
  logic [15:0] adr_reg;
  logic [7:0] lb_reg;
  logic lb_ld;
  logic [10:0] cnt_reg;
  logic [15:0] bs;
  assign wr_done = psel && penable && pready && pwrite && !pslverr;
  assign bs = 16'h8000 - {3'h0, boot_size_opt, 9'h000};
  assign trig_ok = wr_done && paddr == OFS_CMD && pwdata[7:0] == CMD_KEY2 && key_reg
    && en_reg && mode_reg inside {3'h1, 3'h2, 3'h3} && adr_reg < bs
    && (mode_reg == 3'h1 || exec_from_boot || adr_reg >= {lb_reg, 8'h00});
  // Shadow of the programmer-visible setup
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      en_reg <= 1'b0;
      mode_reg <= 3'h0;
      adr_reg <= 16'h0000;
      lb_reg <= 8'h00;
      lb_ld <= 1'b0;
    end
    else
    begin
      // Option value taken at the first edge after release
      if (!lb_ld)
      begin
        lb_reg <= low_bound_opt;
        lb_ld <= 1'b1;
      end
      if (wr_done)
      begin
        if (paddr == OFS_CTRL)
          en_reg <= pwdata[EN_BIT] && pwdata[7:5] != SWRST_USER;
        if (paddr == OFS_MODE)
          mode_reg <= pwdata[2:0];
        if (paddr == OFS_ADRH)
          adr_reg[15:8] <= pwdata[7:0];
        if (paddr == OFS_ADRL)
          adr_reg[7:0] <= pwdata[7:0];
        if (paddr == OFS_LOWB)
        begin
          lb_reg <= pwdata[7:0];
          lb_ld <= 1'b1;
        end
      end
    end
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      key_reg <= 1'b0;
    else if (psel && penable && pready && pwrite)
      key_reg <= paddr == OFS_CMD && pwdata[7:0] == CMD_KEY1 && !pslverr;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      cnt_reg <= 11'h000;
    else
      cnt_reg <= cpu_stall ? cnt_reg + 11'h001 : 11'h000;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_swrst;
    wr_done && paddr == OFS_CTRL && pwdata[7:5] == SWRST_USER;
  endsequence
  sequence s_start;
    $rose(cpu_stall);
  endsequence
  swrst_pulse_a: assert property (s_swrst |-> ##[1:2] soft_reset_user)
    else $error("soft reset pulse missing");
  swrst_once_a: assert property (soft_reset_user |=> !soft_reset_user)
    else $error("soft reset pulse too long");
  launch_run_a: assert property (trig_ok |-> ##[1:2] cpu_stall)
    else $error("valid trigger did not stall");
  launch_cause_a: assert property (s_start |-> $past(trig_ok) || $past(trig_ok, 2))
    else $error("stall without valid trigger");
  stall_hold_a: assert property (cpu_stall |-> !pready)
    else $error("access ended during stall");
  short_op_a: assert property (s_start ##0 mode_reg != 3'h3 |-> ##[1:8] !cpu_stall)
    else $error("read or program too long");
  erase_end_a: assert property (s_start ##0 mode_reg == 3'h3 |-> ##[1:600] !cpu_stall)
    else $error("erase never ends");
  erase_len_a: assert property ($fell(cpu_stall) && mode_reg == 3'h3 |-> cnt_reg >= 11'd512)
    else $error("erase too short");
endmodule : fsps_chk
bind fsps_sequencer fsps_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .exec_from_boot(exec_from_boot), .boot_size_opt(boot_size_opt),
  .low_bound_opt(low_bound_opt), .cpu_stall(cpu_stall), .soft_reset_user(soft_reset_user));

// ### dv/flash_self_program_sequencer_bench.sv
// Self-checking bench of the sequencer over APB.
// Assumes 1K boot region and data low bound 0x7800 from options.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module flash_self_program_sequencer_bench;
  import fsps_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, exec_from_boot = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, exp_v;
  logic pready, pslverr, cpu_stall, soft_reset_user, last_err;
  logic [3:0] boot_size_opt = 4'h2;
  logic [7:0] low_bound_opt = 8'h78;
  int n_errors = 0, n_checks = 0, seed = 68, n_swrst = 0;
  logic [31:0] exp_q [$];
  logic [20:0] bad [6] = '{21'h010000, 21'h100000, 21'h190000, 21'h117C00, 21'h118000,
    21'h150000};
  always #2 clk = ~clk;
  fsps_sequencer u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exec_from_boot(exec_from_boot), .boot_size_opt(boot_size_opt),
    .low_bound_opt(low_bound_opt), .cpu_stall(cpu_stall), .soft_reset_user(soft_reset_user));
  fsps_flash_ref u_ref ();
  always @(posedge clk)
  begin
    if (soft_reset_user === 1'b1)
      n_swrst++;
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      exp_v = exp_q.pop_front();
      `CHK(prdata, exp_v)
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 3000)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= 3000)
    begin
      n_errors++;
      $display("MISMATCH %0t apb access timed out", $time);
    end
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic op(input logic en, brk, input logic [2:0] m, input logic [15:0] a,
    input logic [7:0] d);
    wr(OFS_CTRL, {en, 7'h00});
    wr(OFS_MODE, {5'h00, m});
    wr(OFS_ADRH, a[15:8]);
    wr(OFS_ADRL, a[7:0]);
    wr(OFS_DATA, d);
    wr(OFS_CMD, CMD_KEY1);
    if (brk)
      wr(OFS_ADRL, a[7:0]);
    wr(OFS_CMD, CMD_KEY2);
    wr(OFS_MODE, 8'h00);
    wr(OFS_CTRL, 8'h00);
  endtask : op
  task automatic chk_byte(input logic [15:0] a);
    op(1'b1, 1'b0, 3'h1, a, 8'h00);
    rd(OFS_DATA, {24'h0, u_ref.mem[a[14:0]]});
  endtask : chk_byte
  initial
  begin
    #(4 * 40000);
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_of_test();
  end
  initial
  begin
    logic [7:0] d;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    op(1'b1, 1'b0, 3'h3, 16'h0000, 8'h00);
    u_ref.erase(16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      d = $random(seed);
      op(1'b1, 1'b0, 3'h2, {14'h0, i[1:0]}, d);
      u_ref.prog({14'h0, i[1:0]}, d);
    end
    for (int i = 0; i < 4; i++)
      chk_byte({14'h0, i[1:0]});
    exec_from_boot <= 1'b0;
    op(1'b1, 1'b0, 3'h2, 16'h0001, 8'h00);
    chk_byte(16'h0001);
    op(1'b1, 1'b0, 3'h3, 16'h7800, 8'h00);
    u_ref.erase(16'h7800);
    d = $random(seed);
    op(1'b1, 1'b0, 3'h2, 16'h7801, d);
    u_ref.prog(16'h7801, d);
    chk_byte(16'h7801);
    for (int i = 0; i < 6; i++)
    begin
      op(bad[i][20], bad[i][19], bad[i][18:16], bad[i][15:0], 8'h5A + i[7:0]);
      rd(OFS_DATA, 32'h5A + i);
    end
    rd(OFS_STAT, 32'h22);
    wr(OFS_STAT, 8'h02);
    rd(OFS_STAT, 32'h20);
    wr(OFS_LOWB, 8'h70);
    op(1'b1, 1'b0, 3'h3, 16'h7000, 8'h00);
    u_ref.erase(16'h7000);
    chk_byte(16'h7000);
    rd(8'h20, 32'h0);
    `CHK(last_err, 1'b1)
    wr(OFS_CTRL, 8'h20);
    repeat (3) @(posedge clk);
    `CHK(n_swrst, 1)
    end_of_test();
  end
endmodule : flash_self_program_sequencer_bench
